// ---- hw/mrh_device.sv ----
// Operation
// - Host presents address before any strobe
// - Address captured on latch strobe fall
// - Active-high latch strobe splits address, data
// - Write data stored on write strobe rise
// - Read data driven late in read low
// - Read strobe high ends read, releases bus
// - Host asserts chip select for access
// - Chip select held during any strobe
// - Deselected cycle latches address, no access
// - Power control is active-low open drain
// - Without main supply, key or alarm wakes
// - Powered, control bits steer power output
// - Timebase from 32.768 kHz oscillator input
// - Read strobe enables device output buffers
// - Write strobe marks register write interval
// - Wake key falling edge triggers power on
`timescale 1ns/1ps
`default_nettype none

module mrh_device
    import mrh_pkg::*;
#(
    parameter int DEPTH = MRH_MEM_DEPTH
)
(
    input  wire logic CLOCK,
    input  wire logic RST_N,
    input  wire logic CLK_EN,
    mrh_bus_if.device BUS,
    input  wire logic MAIN_SUPPLY_OK,
    input  wire logic WAKE_KEY_IN_N,
    input  wire logic WAKE_ALARM,
    input  wire logic OSC_IN,
    output logic      OSC_OUT,
    output logic      OSC_OUT_OE_N,
    output logic      POWER_ON_CONTROL_N_O,
    output logic      POWER_ON_CONTROL_N_OE_N,
    output logic      OSC_TICK
);

    // Two-flop synchronisers for the bus, strobe, chip select, wake key and oscillator pins; supply and alarm are used directly
    localparam int NSYNC = 14;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1_q, s1_d;
    logic [NSYNC-1:0] s2_q, s2_d;
    logic [NSYNC-1:0] s3_q, s3_d;

    assign raw_in = {BUS.muxed_bus_lines, BUS.ale, BUS.cs_n, BUS.rd_n,
                     BUS.wr_n, WAKE_KEY_IN_N, OSC_IN};

    logic [7:0] bus_s;
    logic       ale_s, cs_n_s, rd_n_s, wr_n_s, key_n_s, osc_s;
    logic       ale_p, rd_n_p, wr_n_p, key_n_p, osc_p;
    assign {bus_s, ale_s, cs_n_s, rd_n_s, wr_n_s, key_n_s, osc_s} = s2_q;
    assign ale_p   = s3_q[5];
    assign rd_n_p  = s3_q[3];
    assign wr_n_p  = s3_q[2];
    assign key_n_p = s3_q[1];
    assign osc_p   = s3_q[0];

    logic [MRH_ADDR_W-1:0] addr_q, addr_d;
    logic [MRH_DATA_W-1:0] mem_q [DEPTH];
    logic [MRH_DATA_W-1:0] mem_d [DEPTH];
    logic [MRH_DATA_W-1:0] rdata_q, rdata_d;
    logic                  sel_q, sel_d;
    logic [3:0]            rd_cnt_q, rd_cnt_d;
    logic                  oe_q, oe_d;
    logic                  pwr_on_q, pwr_on_d;
    logic                  tick_q, tick_d;
    logic                  mem_we;
    logic                  cs_ok;

    // Deselected cycles still latch the address
    assign cs_ok  = !cs_n_s;
    assign mem_we = wr_n_s && !wr_n_p && sel_q;

    always_comb
    begin
        s1_d     = raw_in;
        s2_d     = s1_q;
        s3_d     = s2_q;
        addr_d   = addr_q;
        sel_d    = sel_q;
        rdata_d  = rdata_q;
        rd_cnt_d = rd_cnt_q;
        oe_d     = oe_q;
        pwr_on_d = pwr_on_q;
        tick_d   = osc_s && !osc_p;
        if (!ale_s && ale_p)
        begin
            addr_d = bus_s;
            sel_d  = 1'b0;
        end
        if (!rd_n_s || !wr_n_s)
        begin
            sel_d = sel_q | cs_ok;
        end
        if (!rd_n_s && sel_d)
        begin
            if (rd_n_p)
            begin
                rd_cnt_d = 4'h0;
                rdata_d  = mem_q[addr_q];
            end
            else if (rd_cnt_q != 4'(MRH_RD_DLY_CYC))
            begin
                rd_cnt_d = rd_cnt_q + 4'h1;
            end
            else
            begin
                oe_d = 1'b1;
            end
        end
        else
        begin
            oe_d = 1'b0;
        end
        if (rd_n_s && wr_n_s && !rd_n_p)
        begin
            sel_d = 1'b0;
        end
        if (!MAIN_SUPPLY_OK)
        begin
            if ((!key_n_s && key_n_p) || WAKE_ALARM)
            begin
                pwr_on_d = 1'b1;
            end
        end
        else if (mem_we && addr_q == MRH_PWR_CTRL_ADDR)
        begin
            if (bus_s[MRH_PWR_OFF_BIT])
            begin
                pwr_on_d = 1'b0;
            end
            else if (bus_s[MRH_PWR_ON_BIT])
            begin
                pwr_on_d = 1'b1;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++)
        begin : g_mem
            always_comb
            begin
                mem_d[gi] = mem_q[gi];
                if (mem_we && addr_q == MRH_ADDR_W'(gi))
                begin
                    mem_d[gi] = bus_s;
                end
            end

            always_ff @(posedge CLOCK or negedge RST_N)
            begin
                if (!RST_N)
                begin
                    mem_q[gi] <= MRH_MEM_RESET;
                end
                else if (CLK_EN)
                begin
                    mem_q[gi] <= mem_d[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            // Latch strobe resets to its idle low level, so no false fall
            s1_q     <= MRH_SYNC_RESET;
            s2_q     <= MRH_SYNC_RESET;
            s3_q     <= MRH_SYNC_RESET;
            addr_q   <= MRH_ADDR_RESET;
            sel_q    <= 1'b0;
            rdata_q  <= MRH_MEM_RESET;
            rd_cnt_q <= 4'h0;
            oe_q     <= 1'b0;
            pwr_on_q <= 1'b0;
            tick_q   <= 1'b0;
        end
        else if (CLK_EN)
        begin
            s1_q     <= s1_d;
            s2_q     <= s2_d;
            s3_q     <= s3_d;
            addr_q   <= addr_d;
            sel_q    <= sel_d;
            rdata_q  <= rdata_d;
            rd_cnt_q <= rd_cnt_d;
            oe_q     <= oe_d;
            pwr_on_q <= pwr_on_d;
            tick_q   <= tick_d;
        end
    end

    assign BUS.dev_out              = rdata_q;
    assign BUS.dev_oe_n             = !(oe_q && !rd_n_s);
    // Open drain: only ever pulls low
    assign POWER_ON_CONTROL_N_O     = 1'b0;
    assign POWER_ON_CONTROL_N_OE_N  = !pwr_on_q;
    // External oscillator assumed, so the output is left floating
    assign OSC_OUT                  = 1'b0;
    assign OSC_OUT_OE_N             = 1'b1;
    assign OSC_TICK                 = tick_q;

endmodule : mrh_device

`default_nettype wire

// ---- hw/mrh_pkg.sv ----
package mrh_pkg;

    localparam int          MRH_ADDR_W        = 8;
    localparam int          MRH_DATA_W        = 8;
    localparam int          MRH_MEM_DEPTH     = 256;
    // Control register byte and bits that steer the power-on output
    localparam logic [7:0]  MRH_PWR_CTRL_ADDR = 8'h7F;
    localparam int          MRH_PWR_ON_BIT    = 0;
    localparam int          MRH_PWR_OFF_BIT   = 1;
    localparam logic [7:0]  MRH_MEM_RESET     = 8'h00;
    localparam logic [7:0]  MRH_ADDR_RESET    = 8'h00;
    // Pin synchronisers: latch strobe low; bus, chip select, strobes, key, osc high
    localparam logic [13:0] MRH_SYNC_RESET    = 14'h3FDF;
    // Timebase
    localparam int          MRH_OSC_HZ        = 32768;
    localparam int          MRH_CLK_HZ        = 100000000;
    // Host timing, in ns and in 10 ns cycles
    localparam int          MRH_CLK_NS        = 10;
    localparam int          MRH_ALE_HIGH_NS   = 40;
    localparam int          MRH_ALE_HIGH_CYC  =
        (MRH_ALE_HIGH_NS + MRH_CLK_NS - 1) / MRH_CLK_NS;
    localparam int          MRH_STROBE_LOW_NS = 200;
    localparam int          MRH_STROBE_CYC    =
        (MRH_STROBE_LOW_NS + MRH_CLK_NS - 1) / MRH_CLK_NS;
    localparam int          MRH_SETUP_NS      = 30;
    localparam int          MRH_SETUP_CYC     =
        (MRH_SETUP_NS + MRH_CLK_NS - 1) / MRH_CLK_NS;
    // Device turns its drivers on one cycle after its read counter reaches this
    localparam int          MRH_RD_DLY_NS     = 20;
    localparam int          MRH_RD_DLY_CYC    =
        (MRH_RD_DLY_NS + MRH_CLK_NS - 1) / MRH_CLK_NS;

    typedef enum logic [2:0]
    {
        MRH_IDLE   = 3'b000,
        MRH_ADDR   = 3'b001,
        MRH_ALE_LO = 3'b011,
        MRH_STROBE = 3'b010,
        MRH_HOLD   = 3'b110,
        MRH_DONE   = 3'b111
    } mrh_host_state_type;

endpackage : mrh_pkg

// ---- hw/mrh_bus_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface mrh_bus_if;
    import mrh_pkg::*;

    logic                  ale;
    logic                  cs_n;
    logic                  rd_n;
    logic                  wr_n;
    logic [MRH_DATA_W-1:0] host_out;
    logic                  host_oe_n;
    logic [MRH_DATA_W-1:0] dev_out;
    logic                  dev_oe_n;
    logic [MRH_DATA_W-1:0] muxed_bus_lines;

    // Resolved bus: undriven lines read as pulled-up
    assign muxed_bus_lines = !host_oe_n ? host_out :
                             !dev_oe_n  ? dev_out  : 8'hFF;

    modport device
    (
        input  ale,
        input  cs_n,
        input  rd_n,
        input  wr_n,
        input  muxed_bus_lines,
        output dev_out,
        output dev_oe_n
    );

    modport host
    (
        output ale,
        output cs_n,
        output rd_n,
        output wr_n,
        output host_out,
        output host_oe_n,
        input  muxed_bus_lines
    );

endinterface : mrh_bus_if

`default_nettype wire

// ---- hw/mrh_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module mrh_host
    import mrh_pkg::*;
(
    input  wire logic                  CLOCK,
    input  wire logic                  RST_N,
    input  wire logic                  CLK_EN,
    mrh_bus_if.host                    BUS,
    input  wire logic                  REQ_VALID,
    output logic                       REQ_READY,
    input  wire logic                  REQ_WRITE,
    input  wire logic                  REQ_SELECT,
    input  wire logic [MRH_ADDR_W-1:0] REQ_ADDR,
    input  wire logic [MRH_DATA_W-1:0] REQ_WDATA,
    output logic                       RSP_VALID,
    output logic [MRH_DATA_W-1:0]      RSP_RDATA
);

    localparam int CNT_MAX = MRH_STROBE_CYC + MRH_SETUP_CYC + 4;

    mrh_host_state_type    st_q, st_d;
    logic [5:0]            cnt_q, cnt_d;
    logic                  wr_q, wr_d;
    logic                  sel_q, sel_d;
    logic [MRH_DATA_W-1:0] wdat_q, wdat_d;
    logic [MRH_ADDR_W-1:0] adr_q, adr_d;
    logic [MRH_DATA_W-1:0] rdat_q, rdat_d;
    logic                  rsp_q, rsp_d;
    logic [MRH_DATA_W-1:0] bus_s1_q, bus_s2_q;

    always_comb
    begin
        st_d   = st_q;
        cnt_d  = cnt_q + 6'h1;
        wr_d   = wr_q;
        sel_d  = sel_q;
        wdat_d = wdat_q;
        adr_d  = adr_q;
        rdat_d = rdat_q;
        rsp_d  = 1'b0;
        case (st_q)
            MRH_IDLE:
            begin
                cnt_d = 6'h0;
                if (REQ_VALID)
                begin
                    wr_d   = REQ_WRITE;
                    sel_d  = REQ_SELECT;
                    adr_d  = REQ_ADDR;
                    wdat_d = REQ_WDATA;
                    st_d   = MRH_ADDR;
                end
            end
            MRH_ADDR:
                if (cnt_q == 6'(MRH_ALE_HIGH_CYC))
                begin
                    st_d  = MRH_ALE_LO;
                    cnt_d = 6'h0;
                end
            MRH_ALE_LO:
                if (cnt_q == 6'(MRH_SETUP_CYC))
                begin
                    st_d  = MRH_STROBE;
                    cnt_d = 6'h0;
                end
            MRH_STROBE:
                if (cnt_q == 6'(CNT_MAX))
                begin
                    rdat_d = bus_s2_q;
                    st_d   = MRH_HOLD;
                    cnt_d  = 6'h0;
                end
            MRH_HOLD:
                if (cnt_q == 6'(MRH_SETUP_CYC))
                begin
                    st_d  = MRH_DONE;
                    rsp_d = 1'b1;
                end
            MRH_DONE:
                st_d = MRH_IDLE;
            default:
                st_d = MRH_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            st_q     <= MRH_IDLE;
            cnt_q    <= 6'h0;
            wr_q     <= 1'b0;
            sel_q    <= 1'b0;
            wdat_q   <= 8'h00;
            adr_q    <= MRH_ADDR_RESET;
            rdat_q   <= 8'h00;
            rsp_q    <= 1'b0;
            bus_s1_q <= 8'hFF;
            bus_s2_q <= 8'hFF;
        end
        else if (CLK_EN)
        begin
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            wr_q     <= wr_d;
            sel_q    <= sel_d;
            wdat_q   <= wdat_d;
            adr_q    <= adr_d;
            rdat_q   <= rdat_d;
            rsp_q    <= rsp_d;
            bus_s1_q <= BUS.muxed_bus_lines;
            bus_s2_q <= bus_s1_q;
        end
    end

    logic strobing;
    assign strobing      = (st_q == MRH_STROBE);
    assign BUS.ale       = (st_q == MRH_ADDR);
    // Chip select spans setup, strobe and hold so it covers the strobe
    assign BUS.cs_n      = !(sel_q && (st_q == MRH_ALE_LO || strobing ||
                             st_q == MRH_HOLD));
    assign BUS.rd_n      = !(strobing && !wr_q);
    assign BUS.wr_n      = !(strobing && wr_q);
    // Write data stays on the lines through hold, past the strobe rise
    // Address stays on the lines past the latch fall for hold time
    assign BUS.host_out  = (st_q == MRH_ADDR || st_q == MRH_ALE_LO) ?
                           adr_q : wdat_q;
    assign BUS.host_oe_n = !(st_q == MRH_ADDR || st_q == MRH_ALE_LO ||
                             (wr_q && (strobing || st_q == MRH_HOLD)));
    assign REQ_READY     = (st_q == MRH_IDLE);
    assign RSP_VALID     = rsp_q;
    assign RSP_RDATA     = rdat_q;

endmodule : mrh_host

`default_nettype wire

// ---- testbench/mrh_bus_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module mrh_bus_assertions
    import mrh_pkg::*;
(
    input wire logic                  CLOCK,
    input wire logic                  RST_N,
    input wire logic                  ale,
    input wire logic                  cs_n,
    input wire logic                  rd_n,
    input wire logic                  wr_n,
    input wire logic [MRH_DATA_W-1:0] host_out,
    input wire logic                  host_oe_n,
    input wire logic [MRH_DATA_W-1:0] dev_out,
    input wire logic                  dev_oe_n,
    input wire logic [MRH_DATA_W-1:0] muxed_bus_lines
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    property p_ale_pulse;
        $rose(ale) |-> ale[*5] ##1 !ale;
    endproperty
    a_ale_pulse: assert property (p_ale_pulse)
        else $error("latch strobe width wrong");
    property p_addr_held;
        $fell(ale) |-> !host_oe_n && $stable(muxed_bus_lines);
    endproperty
    a_addr_held: assert property (p_addr_held)
        else $error("address not held at latch fall");
    property p_ale_idle;
        ale |-> rd_n && wr_n;
    endproperty
    a_ale_idle: assert property (p_ale_idle)
        else $error("strobe during latch pulse");
    property p_no_overlap;
        !rd_n |-> wr_n;
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("read and write strobes overlap");
    property p_cs_hold;
        $rose(cs_n) |-> rd_n && wr_n;
    endproperty
    a_cs_hold: assert property (p_cs_hold)
        else $error("chip select dropped during strobe");
    property p_rd_late;
        $fell(rd_n) |-> dev_oe_n[*3];
    endproperty
    a_rd_late: assert property (p_rd_late)
        else $error("read data driven too early");
    property p_rd_drive;
        $fell(rd_n) && !cs_n |-> ##[3:12] !dev_oe_n;
    endproperty
    a_rd_drive: assert property (p_rd_drive)
        else $error("read data never driven");
    property p_release;
        rd_n[*5] |-> dev_oe_n;
    endproperty
    a_release: assert property (p_release)
        else $error("bus not released after read");
    property p_desel;
        cs_n[*4] |-> dev_oe_n;
    endproperty
    a_desel: assert property (p_desel)
        else $error("deselected device drives bus");
    property p_wr_data;
        $rose(wr_n) |-> !host_oe_n && dev_oe_n;
    endproperty
    a_wr_data: assert property (p_wr_data)
        else $error("write data missing at strobe rise");

    c_write: cover property ($rose(wr_n) && !cs_n);
    c_read: cover property ($fell(dev_oe_n));
    c_desel: cover property (!rd_n && cs_n);
endmodule : mrh_bus_assertions

`default_nettype wire

// ---- testbench/tb_muxed_bus_rtc_host_port.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_muxed_bus_rtc_host_port;
    import mrh_pkg::*;
    logic       clock;
    logic       rst_n;
    logic       clk_en;
    logic       req_valid;
    logic       req_write;
    logic       req_select;
    logic [7:0] req_addr;
    logic [7:0] req_wdata;
    logic [7:0] rdata;
    logic       req_ready;
    logic       rsp_valid;
    logic [7:0] rsp_rdata;
    logic       supply_ok;
    logic       key_n;
    logic       alarm;
    logic       osc_in;
    logic       osc_oe_n;
    logic       pwr_o;
    logic       pwr_oe_n;
    logic       osc_tick;
    int         errors;
    int         checked;

    mrh_bus_if mrh_bus_if_i ();
    mrh_host mrh_host_i (.CLOCK(clock), .RST_N(rst_n), .CLK_EN(clk_en),
        .BUS(mrh_bus_if_i), .REQ_VALID(req_valid), .REQ_READY(req_ready),
        .REQ_WRITE(req_write), .REQ_SELECT(req_select),
        .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
        .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata));
    mrh_device mrh_device_i (.CLOCK(clock), .RST_N(rst_n), .CLK_EN(clk_en),
        .BUS(mrh_bus_if_i), .MAIN_SUPPLY_OK(supply_ok),
        .WAKE_KEY_IN_N(key_n), .WAKE_ALARM(alarm), .OSC_IN(osc_in),
        .OSC_OUT(), .OSC_OUT_OE_N(osc_oe_n), .POWER_ON_CONTROL_N_O(pwr_o),
        .POWER_ON_CONTROL_N_OE_N(pwr_oe_n), .OSC_TICK(osc_tick));
    mrh_bus_assertions mrh_bus_assertions_i (.CLOCK(clock), .RST_N(rst_n),
        .ale(mrh_bus_if_i.ale), .cs_n(mrh_bus_if_i.cs_n),
        .rd_n(mrh_bus_if_i.rd_n), .wr_n(mrh_bus_if_i.wr_n),
        .host_out(mrh_bus_if_i.host_out),
        .host_oe_n(mrh_bus_if_i.host_oe_n),
        .dev_out(mrh_bus_if_i.dev_out), .dev_oe_n(mrh_bus_if_i.dev_oe_n),
        .muxed_bus_lines(mrh_bus_if_i.muxed_bus_lines));

    task summarize;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task xfer(input logic w, input logic s, input logic [7:0] a,
              input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clock);
        req_valid = 1'b1;
        req_write = w;
        req_select = s;
        req_addr = a;
        req_wdata = d;
        while (req_ready !== 1'b1 && n < 100)
        begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 200)
        begin
            @(negedge clock);
            n++;
        end
        chk({7'h0, rsp_valid}, 8'h01);
        rdata = rsp_rdata;
    endtask : xfer

    // Power output comes through input synchronisers, so allow some slack
    task wait_pwr(input logic exp);
        int n;
        n = 0;
        while (pwr_oe_n !== exp && n < 30)
        begin
            @(negedge clock);
            n++;
        end
        chk({7'h0, pwr_oe_n}, {7'h0, exp});
    endtask : wait_pwr

    task t_mem;
        xfer(1'b0, 1'b1, 8'h00, 8'h00);
        chk(rdata, MRH_MEM_RESET);
        xfer(1'b1, 1'b1, 8'h12, 8'hA5);
        xfer(1'b1, 1'b1, 8'h13, 8'h5A);
        xfer(1'b0, 1'b1, 8'h12, 8'h00);
        chk(rdata, 8'hA5);
        xfer(1'b0, 1'b1, 8'h13, 8'h00);
        chk(rdata, 8'h5A);
    endtask : t_mem

    task t_desel;
        xfer(1'b1, 1'b0, 8'h12, 8'h3C);
        xfer(1'b0, 1'b0, 8'h12, 8'h00);
        chk(rdata, 8'hFF);
        xfer(1'b0, 1'b1, 8'h12, 8'h00);
        chk(rdata, 8'hA5);
    endtask : t_desel

    // Both ends freeze together, so a stalled read still returns its byte
    task t_freeze;
        fork
            xfer(1'b0, 1'b1, 8'h12, 8'h00);
            begin
                repeat (25) @(negedge clock);
                clk_en = 1'b0;
                repeat (20) @(negedge clock);
                chk({7'h0, mrh_bus_if_i.rd_n}, 8'h00);
                clk_en = 1'b1;
            end
        join
        chk(rdata, 8'hA5);
    endtask : t_freeze

    task t_power;
        chk({7'h0, pwr_oe_n}, 8'h01);
        chk({7'h0, pwr_o}, 8'h00);
        xfer(1'b1, 1'b1, MRH_PWR_CTRL_ADDR, 8'h01 << MRH_PWR_ON_BIT);
        wait_pwr(1'b0);
        xfer(1'b1, 1'b1, MRH_PWR_CTRL_ADDR, 8'h01 << MRH_PWR_OFF_BIT);
        wait_pwr(1'b1);
        @(negedge clock);
        supply_ok = 1'b0;
        alarm = 1'b1;
        @(negedge clock);
        alarm = 1'b0;
        wait_pwr(1'b0);
        supply_ok = 1'b1;
        xfer(1'b1, 1'b1, MRH_PWR_CTRL_ADDR, 8'h01 << MRH_PWR_OFF_BIT);
        wait_pwr(1'b1);
        @(negedge clock);
        supply_ok = 1'b0;
        key_n = 1'b0;
        wait_pwr(1'b0);
        key_n = 1'b1;
        supply_ok = 1'b1;
    endtask : t_power

    task t_osc;
        int ticks;
        int i;
        ticks = 0;
        // Four rising edges twenty cycles apart; the tail lets the last out
        for (i = 0; i < 86; i++)
        begin
            @(negedge clock);
            if (osc_tick === 1'b1)
                ticks++;
            osc_in = (i % 20 >= 10) && (i < 80);
        end
        chk(8'(ticks), 8'h04);
        chk({7'h0, osc_oe_n}, 8'h01);
    endtask : t_osc

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial
    begin
        #200000;
        errors++;
        summarize();
    end

    initial
    begin
        errors = 0;
        checked = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_select = 1'b0;
        req_addr = 8'h00;
        req_wdata = 8'h00;
        rdata = 8'h00;
        supply_ok = 1'b1;
        key_n = 1'b1;
        alarm = 1'b0;
        osc_in = 1'b0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        t_mem();
        t_desel();
        t_freeze();
        t_power();
        t_osc();
        summarize();
    end
endmodule : tb_muxed_bus_rtc_host_port

`default_nettype wire
